/* File: clk_gating_regs.svh */
// Register offsets, field positions and reset values of the clock gating block
`ifndef CLK_GATING_REGS_SVH
`define CLK_GATING_REGS_SVH

`define CG_OFF_RCC          12'h100
`define CG_OFF_RUN_PERIPH   12'h104
`define CG_OFF_RUN_PORTS    12'h108
`define CG_OFF_SLP_PERIPH   12'h114
`define CG_OFF_SLP_PORTS    12'h118
`define CG_OFF_DSL_PERIPH   12'h124
`define CG_OFF_DSL_PORTS    12'h128
`define CG_OFF_IRQ_STATUS   12'h130
`define CG_OFF_IRQ_MASK     12'h134

`define CG_PERIPH_MASK      32'h071f0013
`define CG_PORTS_MASK       32'h000000ff
`define CG_ACG_BIT          27
`define CG_RCC_MASK         32'h08000000
`define CG_GATE_RESET       32'h00000000
`define CG_ST_FAULT         0
`define CG_ST_SLVERR        1
`define CG_ST_MASK          32'h00000003
`define CG_UNIT_COUNT       18

`endif

/* File: clk_gating_pkg.sv */
// Types shared by the clock gating block
`default_nettype none
package clk_gating_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } op_mode_t;

    typedef struct packed {
        logic [31:0] periph;
        logic [31:0] ports;
    } gate_set_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] unit;
    } unit_req_t;

endpackage : clk_gating_pkg

`default_nettype wire

/* File: clk_gate_cell.sv */
// Latch based glitch-free clock gate
`timescale 1ns/1ps
`default_nettype none

module clk_gate_cell (
    input  wire logic clkIn,
    input  wire logic enable,
    output logic      clkOut
);
    logic enLatch;

    // Enable only changes while the clock is low, so no pulse is truncated
    always_latch begin
        if (!clkIn) begin
            enLatch <= enable;
        end
    end

    assign clkOut = clkIn & enLatch;
endmodule : clk_gate_cell

`default_nettype wire

/* File: peripheral_clock_gating.sv */
// Peripheral clock gating control with APB register access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "clk_gating_regs.svh"


module peripheral_clock_gating #(
    parameter int UNITS = `CG_UNIT_COUNT
) (
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire logic [11:0]                paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       sleepMode,
    input  wire logic                       deepSleepMode,
    input  wire clk_gating_pkg::unit_req_t  unitReq,
    output logic                            busFault,
    output logic      [UNITS-1:0]           unitClkEn,
    output logic      [UNITS-1:0]           unitClk,
    output logic                            irq
);
    // ************************************************************
    // Register state
    // ************************************************************
    clk_gating_pkg::gate_set_t runSet_reg,  runSet_next;
    clk_gating_pkg::gate_set_t slpSet_reg,  slpSet_next;
    clk_gating_pkg::gate_set_t dslSet_reg,  dslSet_next;
    clk_gating_pkg::op_mode_t  mode_reg,    mode_next;
    logic [31:0]               rcc_reg,     rcc_next;
    logic [31:0]               status_reg,  status_next;
    logic [31:0]               mask_reg,    mask_next;
    logic [31:0]               prdata_reg,  prdata_next;
    logic                      pready_reg,  pready_next;
    logic                      slverr_reg,  slverr_next;
    logic                      fault_reg,   fault_next;
    logic                      irq_reg,     irq_next;
    logic [UNITS-1:0]          clkEn_reg,   clkEn_next;

    logic        setupPhase;
    logic        accessDone;
    logic        wrDone;
    logic        rdDone;
    logic        mapped;
    logic [31:0] readMux;
    logic        acgOn;
    logic [UNITS-1:0] runUnits;
    logic [UNITS-1:0] slpUnits;
    logic [UNITS-1:0] dslUnits;
    logic [UNITS-1:0] selUnits;
    logic        faultEvent;

    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready_reg;
    assign wrDone     = accessDone & pwrite & ~slverr_reg;
    assign rdDone     = accessDone & ~pwrite;
    assign acgOn      = rcc_reg[`CG_ACG_BIT];

    // ************************************************************
    // Unit vectors: async 0..1, sync serial, timers, comparators, ports
    // ************************************************************
    assign runUnits = {runSet_reg.ports[7:0], runSet_reg.periph[26:24],
                       runSet_reg.periph[19:16], runSet_reg.periph[4],
                       runSet_reg.periph[1:0]};
    assign slpUnits = {slpSet_reg.ports[7:0], slpSet_reg.periph[26:24],
                       slpSet_reg.periph[19:16], slpSet_reg.periph[4],
                       slpSet_reg.periph[1:0]};
    assign dslUnits = {dslSet_reg.ports[7:0], dslSet_reg.periph[26:24],
                       dslSet_reg.periph[19:16], dslSet_reg.periph[4],
                       dslSet_reg.periph[1:0]};

    // ************************************************************
    // Address decode and read mux
    // ************************************************************
    always_comb begin
        mapped  = 1'b1;
        readMux = 32'h00000000;
        case (paddr)
            `CG_OFF_RCC:        readMux = rcc_reg;
            `CG_OFF_RUN_PERIPH: readMux = runSet_reg.periph;
            `CG_OFF_RUN_PORTS:  readMux = runSet_reg.ports;
            `CG_OFF_SLP_PERIPH: readMux = slpSet_reg.periph;
            `CG_OFF_SLP_PORTS:  readMux = slpSet_reg.ports;
            `CG_OFF_DSL_PERIPH: readMux = dslSet_reg.periph;
            `CG_OFF_DSL_PORTS:  readMux = dslSet_reg.ports;
            `CG_OFF_IRQ_STATUS: readMux = status_reg;
            `CG_OFF_IRQ_MASK:   readMux = mask_reg;
            default:            mapped  = 1'b0;
        endcase
    end

    // ************************************************************
    // Bus slave and register writes
    // ************************************************************
    always_comb begin
        runSet_next = runSet_reg;
        slpSet_next = slpSet_reg;
        dslSet_next = dslSet_reg;
        rcc_next    = rcc_reg;
        mask_next   = mask_reg;
        // No wait state: read data comes from a flop loaded in the setup phase
        pready_next = setupPhase;
        prdata_next = setupPhase ? readMux : prdata_reg;
        slverr_next = setupPhase & ~mapped;
        if (wrDone) begin
            // Reserved bits never store, so they read back zero
            case (paddr)
                `CG_OFF_RCC:        rcc_next = pwdata & `CG_RCC_MASK;
                `CG_OFF_RUN_PERIPH:
                    runSet_next.periph = pwdata & `CG_PERIPH_MASK;
                `CG_OFF_RUN_PORTS:
                    runSet_next.ports = pwdata & `CG_PORTS_MASK;
                `CG_OFF_SLP_PERIPH:
                    slpSet_next.periph = pwdata & `CG_PERIPH_MASK;
                `CG_OFF_SLP_PORTS:
                    slpSet_next.ports = pwdata & `CG_PORTS_MASK;
                `CG_OFF_DSL_PERIPH:
                    dslSet_next.periph = pwdata & `CG_PERIPH_MASK;
                `CG_OFF_DSL_PORTS:
                    dslSet_next.ports = pwdata & `CG_PORTS_MASK;
                `CG_OFF_IRQ_MASK:   mask_next = pwdata & `CG_ST_MASK;
                default:            mask_next = mask_reg;
            endcase
        end
    end

    // ************************************************************
    // Operating mode and effective gating
    // ************************************************************
    always_comb begin
        mode_next = clk_gating_pkg::MODE_RUN;
        if (acgOn && deepSleepMode) begin
            mode_next = clk_gating_pkg::MODE_DEEP;
        end else if (acgOn && sleepMode) begin
            mode_next = clk_gating_pkg::MODE_SLEEP;
        end
    end

    always_comb begin
        case (mode_reg)
            clk_gating_pkg::MODE_SLEEP: selUnits = slpUnits;
            clk_gating_pkg::MODE_DEEP:  selUnits = dslUnits;
            default:                    selUnits = runUnits;
        endcase
        clkEn_next = selUnits;
    end

    // ************************************************************
    // Bus fault and interrupt
    // ************************************************************
    assign faultEvent = unitReq.valid &&
                        (unitReq.unit >= 5'(UNITS) ||
                         !clkEn_reg[unitReq.unit]);

    always_comb begin
        fault_next  = faultEvent;
        status_next = status_reg;
        // Clear only bits that were read; a new event still wins
        if (rdDone && paddr == `CG_OFF_IRQ_STATUS) begin
            status_next = status_reg & ~prdata_reg;
        end
        if (faultEvent) begin
            status_next[`CG_ST_FAULT] = 1'b1;
        end
        if (setupPhase && !mapped) begin
            status_next[`CG_ST_SLVERR] = 1'b1;
        end
        irq_next = |(status_reg & mask_reg);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            runSet_reg <= '{`CG_GATE_RESET, `CG_GATE_RESET};
            slpSet_reg <= '{`CG_GATE_RESET, `CG_GATE_RESET};
            dslSet_reg <= '{`CG_GATE_RESET, `CG_GATE_RESET};
            mode_reg   <= clk_gating_pkg::MODE_RUN;
            rcc_reg    <= 32'h00000000;
            status_reg <= 32'h00000000;
            mask_reg   <= 32'h00000000;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            slverr_reg <= 1'b0;
            fault_reg  <= 1'b0;
            irq_reg    <= 1'b0;
            clkEn_reg  <= '0;
        end else begin
            runSet_reg <= runSet_next;
            slpSet_reg <= slpSet_next;
            dslSet_reg <= dslSet_next;
            mode_reg   <= mode_next;
            rcc_reg    <= rcc_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            slverr_reg <= slverr_next;
            fault_reg  <= fault_next;
            irq_reg    <= irq_next;
            clkEn_reg  <= clkEn_next;
        end
    end

    // ************************************************************
    // Gated clocks
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < UNITS; g++) begin : gen_gate
            clk_gate_cell u_gate (
                .clkIn  (ref_clk),
                .enable (clkEn_reg[g]),
                .clkOut (unitClk[g])
            );
        end
    endgenerate

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = slverr_reg;
    assign busFault  = fault_reg;
    assign unitClkEn = clkEn_reg;
    assign irq       = irq_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_reset_zero;
        @(posedge ref_clk)
        sys_rst |=> (runSet_reg == '0 && slpSet_reg == '0 &&
                     dslSet_reg == '0 && clkEn_reg == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("gating bits not zero after reset");

    property p_fault_off;
        @(posedge ref_clk) disable iff (sys_rst)
        (unitReq.valid && unitReq.unit < 5'(UNITS) &&
         !clkEn_reg[unitReq.unit]) |=> busFault;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("no bus fault for gated unit");

    property p_no_fault_on;
        @(posedge ref_clk) disable iff (sys_rst)
        (unitReq.valid && unitReq.unit < 5'(UNITS) &&
         clkEn_reg[unitReq.unit]) |=> !busFault;
    endproperty
    a_no_fault_on: assert property (p_no_fault_on)
        else $error("bus fault for clocked unit");

    property p_run_set;
        @(posedge ref_clk) disable iff (sys_rst)
        (!acgOn && !$past(acgOn)) |=> unitClkEn == $past(runUnits);
    endproperty
    a_run_set: assert property (p_run_set)
        else $error("run set not applied without auto gating");

    property p_sleep_set;
        @(posedge ref_clk) disable iff (sys_rst)
        (acgOn && sleepMode && !deepSleepMode)
            ##1 (acgOn && sleepMode) |=> unitClkEn == $past(slpUnits);
    endproperty
    a_sleep_set: assert property (p_sleep_set)
        else $error("sleep set not applied");

    property p_deep_set;
        @(posedge ref_clk) disable iff (sys_rst)
        (acgOn && deepSleepMode) ##1 (acgOn && deepSleepMode)
            |=> unitClkEn == $past(dslUnits);
    endproperty
    a_deep_set: assert property (p_deep_set)
        else $error("deep sleep set not applied");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        (rdDone && (paddr == `CG_OFF_RUN_PORTS ||
                    paddr == `CG_OFF_SLP_PORTS ||
                    paddr == `CG_OFF_DSL_PORTS))
            |-> (prdata & ~`CG_PORTS_MASK) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved port bits read nonzero");

    property p_deep_periph_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        (wrDone && paddr == `CG_OFF_DSL_PERIPH) |=>
            dslSet_reg.periph == ($past(pwdata) & `CG_PERIPH_MASK);
    endproperty
    a_deep_periph_wr: assert property (p_deep_periph_wr)
        else $error("deep sleep periph write lost");

    property p_run_ports_wr;
        @(posedge ref_clk) disable iff (sys_rst)
        (wrDone && paddr == `CG_OFF_RUN_PORTS) ##1 !acgOn
            |=> unitClkEn[UNITS-1 -: 8] == $past(pwdata[7:0], 2);
    endproperty
    a_run_ports_wr: assert property (p_run_ports_wr)
        else $error("run ports write did not reach unit enables");

    property p_irq;
        @(posedge ref_clk) disable iff (sys_rst)
        (|(status_reg & mask_reg)) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    c_fault: cover property (@(posedge ref_clk) busFault);
    c_sleep: cover property (@(posedge ref_clk)
        mode_reg == clk_gating_pkg::MODE_SLEEP);
    c_deep: cover property (@(posedge ref_clk)
        mode_reg == clk_gating_pkg::MODE_DEEP && unitClkEn != '0);
endmodule : peripheral_clock_gating

`default_nettype wire

/* File: tb.sv */
// Self-checking testbench of the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "clk_gating_regs.svh"

module tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {
        logic        chk;
        logic        err;
        logic [31:0] data;
    } note_t;

    logic                      ref_clk = 1'b0;
    logic                      sys_rst = 1'b1;
    logic [11:0]               paddr = 12'h000;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [31:0]               pwdata = 32'h00000000;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      sleepMode = 1'b0;
    logic                      deepSleepMode = 1'b0;
    clk_gating_pkg::unit_req_t unitReq = '0;
    logic                      busFault;
    logic [17:0]               unitClkEn;
    logic [17:0]               unitClk;
    logic                      irq;
    note_t                     apbQ[$];
    logic                      faultQ[$];
    logic                      reqSeen = 1'b0;
    logic [15:0]               lfsrState = 16'h488a;
    logic [31:0]               runP;
    logic [31:0]               runQ;
    int                        n_mismatch = 0;
    int                        tests_run = 0;
    logic [11:0] offs [9] = '{`CG_OFF_RCC, `CG_OFF_RUN_PERIPH,
        `CG_OFF_RUN_PORTS, `CG_OFF_SLP_PERIPH, `CG_OFF_SLP_PORTS,
        `CG_OFF_DSL_PERIPH, `CG_OFF_DSL_PORTS, `CG_OFF_IRQ_STATUS,
        `CG_OFF_IRQ_MASK};
    logic [31:0] masks [9] = '{`CG_RCC_MASK, `CG_PERIPH_MASK,
        `CG_PORTS_MASK, `CG_PERIPH_MASK, `CG_PORTS_MASK, `CG_PERIPH_MASK,
        `CG_PORTS_MASK, 32'h00000000, `CG_ST_MASK};

    peripheral_clock_gating i_peripheral_clock_gating (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .paddr         (paddr),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .sleepMode     (sleepMode),
        .deepSleepMode (deepSleepMode),
        .unitReq       (unitReq),
        .busFault      (busFault),
        .unitClkEn     (unitClkEn),
        .unitClk       (unitClk),
        .irq           (irq)
    );

    always #10 ref_clk = ~ref_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    function automatic logic [17:0] en(input logic [31:0] p,
                                       input logic [31:0] q);
        return {q[7:0], p[26:24], p[19:16], p[4], p[1:0]};
    endfunction : en

    function automatic logic [31:0] rnd32();
        logic [31:0] v;
        lfsrState = {lfsrState[14:0], ^(lfsrState & 16'hb400)};
        v[31:16] = lfsrState;
        lfsrState = {lfsrState[14:0], ^(lfsrState & 16'hb400)};
        v[15:0] = lfsrState;
        return v;
    endfunction : rnd32

    // Request held until the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wdata, input logic chk,
                       input logic [31:0] exp, input logic err);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= addr;
        pwrite  <= wr;
        pwdata  <= wdata;
        apbQ.push_back('{chk, err, exp});
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check("pready", {31'h0, pready}, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b1, e, 1'b0);
    endtask : rd

    // Clock seen high in the high phase only when enabled
    task automatic checkEn(input logic [31:0] p, input logic [31:0] q);
        repeat (4) @(posedge ref_clk);
        #5;
        check("unitClkEn", {14'h0, unitClkEn}, {14'h0, en(p, q)});
        check("unitClk high", {14'h0, unitClk}, {14'h0, en(p, q)});
        @(negedge ref_clk);
        #5;
        check("unitClk low", {14'h0, unitClk}, 32'h0);
    endtask : checkEn

    task automatic mode(input logic auto_clock_gating_bit, input logic s, input logic d,
                        input logic [31:0] p, input logic [31:0] q);
        wr(`CG_OFF_RCC, {4'h0, auto_clock_gating_bit, 27'h0});
        @(posedge ref_clk);
        sleepMode     <= s;
        deepSleepMode <= d;
        checkEn(p, q);
    endtask : mode

    // Back to back requests to every unit and one to unit 20, beyond the last
    task automatic reqAll(input logic [31:0] p, input logic [31:0] q);
        logic [17:0] e;
        logic [4:0]  k;
        e = en(p, q);
        for (int u = 0; u < 19; u++) begin
            k = (u == 18) ? 5'h14 : 5'(u);
            @(posedge ref_clk);
            unitReq <= '{valid: 1'b1, unit: k};
            faultQ.push_back(u == 18 ? 1'b1 : !e[u]);
        end
        @(posedge ref_clk);
        unitReq <= '0;
        repeat (2) @(posedge ref_clk);
    endtask : reqAll

    // ****************************************************************
    // Checking
    // ****************************************************************
    always @(posedge ref_clk) begin
        note_t n;
        logic  f;
        if (psel && penable && pready === 1'b1 && apbQ.size() > 0) begin
            n = apbQ.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
            if (n.chk) check("prdata", prdata, n.data);
        end
        if (reqSeen && faultQ.size() > 0) begin
            f = faultQ.pop_front();
            check("busFault", {31'h0, busFault}, {31'h0, f});
        end
        reqSeen = unitReq.valid && !sys_rst;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (offs[i]) rd(offs[i], 32'h0);
        checkEn(32'h0, 32'h0);
        foreach (offs[i]) begin
            wr(offs[i], 32'hffffffff);
            rd(offs[i], masks[i]);
        end
        checkEn(`CG_PERIPH_MASK, `CG_PORTS_MASK);
        foreach (offs[i]) wr(offs[i], 32'h0);
        wr(`CG_OFF_RUN_PERIPH, 32'h00000013);
        wr(`CG_OFF_RUN_PORTS, 32'h00000001);
        wr(`CG_OFF_SLP_PERIPH, 32'h070f0000);
        wr(`CG_OFF_SLP_PORTS, 32'h0000000f);
        wr(`CG_OFF_DSL_PERIPH, 32'h01000010);
        wr(`CG_OFF_DSL_PORTS, 32'h000000f0);
        mode(1'b0, 1'b1, 1'b0, 32'h00000013, 32'h01);
        mode(1'b0, 1'b0, 1'b1, 32'h00000013, 32'h01);
        mode(1'b1, 1'b1, 1'b0, 32'h070f0000, 32'h0f);
        reqAll(32'h070f0000, 32'h0f);
        mode(1'b1, 1'b1, 1'b1, 32'h01000010, 32'hf0);
        mode(1'b1, 1'b0, 1'b0, 32'h00000013, 32'h01);
        mode(1'b0, 1'b0, 1'b0, 32'h00000013, 32'h01);
        repeat (3) begin
            runP = rnd32();
            runQ = rnd32();
            wr(`CG_OFF_RUN_PERIPH, runP);
            wr(`CG_OFF_RUN_PORTS, runQ);
            rd(`CG_OFF_RUN_PERIPH, runP & `CG_PERIPH_MASK);
            rd(`CG_OFF_RUN_PORTS, runQ & `CG_PORTS_MASK);
            checkEn(runP, runQ);
            reqAll(runP, runQ);
        end
        // Faults were counted with the mask clear
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(`CG_OFF_IRQ_STATUS, 32'h00000001);
        rd(`CG_OFF_IRQ_STATUS, 32'h00000000);
        apb(1'b0, 12'h200, 32'h0, 1'b0, 32'h0, 1'b1);
        wr(`CG_OFF_IRQ_MASK, 32'h00000002);
        repeat (3) @(posedge ref_clk);
        check("irq set", {31'h0, irq}, 32'h1);
        rd(`CG_OFF_IRQ_STATUS, 32'h00000002);
        repeat (3) @(posedge ref_clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(`CG_OFF_RUN_PERIPH, `CG_PERIPH_MASK);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`CG_OFF_RUN_PERIPH, 32'h0);
        checkEn(32'h0, 32'h0);
        close_out();
    end
endmodule : tb
`default_nettype wire
